// ### verilog/plc_shift_regs.svh
// Purpose: constants for the shift and flow-control engine
// Assumes: included by the design only
// Notes: opcode values are local encodings
`ifndef PLC_SHIFT_REGS_SVH
`define PLC_SHIFT_REGS_SVH
`define OP_WORD_LSL 5'h00
`define OP_WORD_LSR 5'h01
`define OP_PAIR_LSL 5'h02
`define OP_PAIR_LSR 5'h03
`define OP_WORD_ASL 5'h04
`define OP_WORD_ASR 5'h05
`define OP_PAIR_ASL 5'h06
`define OP_PAIR_ASR 5'h07
`define OP_WORD_ROL 5'h08
`define OP_WORD_ROR 5'h09
`define OP_PAIR_ROL 5'h0A
`define OP_PAIR_ROR 5'h0B
`define OP_STACK_PUSH 5'h10
`define OP_STACK_PEEK 5'h11
`define OP_STACK_POP 5'h12
`define OP_JUMP 5'h13
`define OP_END 5'h14
`define OP_NOP 5'h15
`define STACK_DEPTH 8
`define PC_ZERO 16'h0000
`endif

// ### verilog/plc_shift_pkg.sv
// Purpose: types for the shift and flow-control engine
// Assumes: opcode field 5 bits, addresses 8 bits
// Notes: area bit selects parameter area when set
package plc_shift_pkg;
    typedef struct packed {
        logic [4:0] opcode;
        logic area;        // 1 = parameter_register_area
        logic [7:0] addr;  // operand / jump source register
    } instr_t;
    typedef enum logic [2:0] {
        st_fetch,
        st_read_lo,
        st_read_hi,
        st_write_lo,
        st_write_hi,
        st_wait_loop,
        st_halted
    } state_t;
endpackage : plc_shift_pkg

// ### verilog/plc_shift_and_flow_control.sv
// Purpose: one-bit shifts/rotates on words and register pairs, logic stack, jump/end
// Assumes: program memory and register areas answer reads in the same cycle
// Notes: one instruction at a time; fetch, read operand(s), write back
`include "plc_shift_regs.svh"

// engine overview
// one instruction in flight at a time
// no overlap between fetch and write-back
// keeps the register areas free of hazards
// costs a few cycles per shift, fine for a scan loop
//
// fetch cycle
// instruction word taken while state is fetch
// program counter steps by one at that edge, or goes to zero on end
// stack ops and no-ops finish in the fetch cycle
// shifts and jump leave fetch for the read states
//
// register read port
// read strobe, area and address come from flops
// read data is taken in the cycle the strobe stands
// so the register areas must answer combinationally
// a registered memory would need one more read state
//
// word shift timing
// edge 0: fetch, read strobe raised
// edge 1: low word captured, high cleared
// edge 2: write strobe raised for the named register
// edge 3: next fetch
// three cycles per word shift
//
// pair shift timing
// edge 0: fetch, read strobe for the low word
// edge 1: low word captured, read strobe for the high word
// edge 2: high word captured
// edge 3: low half written to the named register
// edge 4: high half written to the next register
// edge 5: next fetch
// five cycles per pair shift
//
// pair addressing
// high word always at named address plus one
// same area for both halves
// address wraps inside the area at the top
// programs should not name the last register of an area
//
// shift unit
// one function covers all twelve shift opcodes
// word results use the low half only
// sign taken from bit 15 or bit 31 by operand size
// logical right fills zero, signed right copies sign
// rotates feed the lost bit into the far end
// signed and logical left shifts are the same operation
//
// logic stack
// bit 0 is the top entry
// push shifts the stack up, pop shifts it down
// depth counter runs from zero to the stack depth
// a push on a full stack is dropped, not wrapped
// the overflow flag stays until reset
// pop on an empty stack does nothing; peek there sets the value from bit 0 but raises no load strobe
// a pop leaves zero in the vacated bottom slot, the highest bit
//
// logic result restore
// load strobe stands one cycle after the fetch edge
// value holds until the next peek or pop
//
// jump
// target read from the working area only
// the operand area bit is ignored for jumps
// timer refresh pulse one cycle after the read
// engine then idles until the next loop start
//
// end
// program counter back to zero at once
// timer refresh pulse one cycle after fetch
// engine idles until the next loop start
//
// loop start
// only looked at while idling
// a pulse during execution is ignored
// so a long program simply misses a pass
//
// running off the end
// a no-op fetched at or past the last address halts
// halt is left only through reset
// a shift past the last address still executes
//
// reset
// synchronous, clears every output and the stack
// engine comes out idle, waiting for a loop start
// first pass always begins at address zero
//
// outputs
// every output is a field of the state register
// status flags are precomputed from the next state
// keeps the status free of decode glitches
//
// opcodes
// encodings are local, see the constants header
// unused codes behave as no-ops

module plc_shift_and_flow_control #(
    parameter int PC_WIDTH = 16,
    parameter int STACK_DEPTH = `STACK_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_loop_start,
    input wire logic [PC_WIDTH-1:0] i_prog_last,
    input wire plc_shift_pkg::instr_t i_instr,
    input wire logic [15:0] i_rd_data,
    input wire logic i_logic_result,
    output logic [PC_WIDTH-1:0] o_pc,
    output logic o_rd_en,
    output logic o_rd_area,
    output logic [7:0] o_rd_addr,
    output logic o_wr_en,
    output logic o_wr_area,
    output logic [7:0] o_wr_addr,
    output logic [15:0] o_wr_data,
    output logic o_logic_load,
    output logic o_logic_value,
    output logic o_timer_refresh,
    output logic o_stack_overflow,
    output logic o_running,
    output logic o_halted
);
    typedef struct packed {
        plc_shift_pkg::state_t state;
        plc_shift_pkg::instr_t ins;
        logic [PC_WIDTH-1:0] pc;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [STACK_DEPTH-1:0] stack;
        logic [3:0] depth;
        logic rd_en;
        logic rd_area;
        logic [7:0] rd_addr;
        logic wr_en;
        logic wr_area;
        logic [7:0] wr_addr;
        logic [15:0] wr_data;
        logic logic_load;
        logic logic_value;
        logic timer_refresh;
        logic overflow;
        logic jump_pending;
        logic running;
        logic halted;
    } core_t;

    core_t core_reg;
    core_t core_next;
    logic [31:0] pair_res;

    // true for opcodes that work on a register pair
    function automatic logic is_pair(input logic [4:0] op);
        is_pair = (op == `OP_PAIR_LSL) || (op == `OP_PAIR_LSR) || (op == `OP_PAIR_ASL)
            || (op == `OP_PAIR_ASR) || (op == `OP_PAIR_ROL) || (op == `OP_PAIR_ROR);
    endfunction : is_pair

    // true for every shift or rotate opcode
    function automatic logic is_shift(input logic [4:0] op);
        is_shift = (op <= `OP_PAIR_ROR);
    endfunction : is_shift

    // one-bit shift unit; word results use the low half only
    function automatic logic [31:0] shift_one(input logic [4:0] op, input logic [31:0] v,
                                              input logic pair);
        logic sign;
        sign = pair ? v[31] : v[15];
        unique case (op)
            `OP_WORD_LSL: shift_one = {16'h0000, v[14:0], 1'b0};
            `OP_WORD_LSR: shift_one = {17'h00000, v[15:1]};
            `OP_WORD_ASL: shift_one = {16'h0000, v[14:0], 1'b0};
            `OP_WORD_ASR: shift_one = {16'h0000, sign, v[15:1]};
            `OP_WORD_ROL: shift_one = {16'h0000, v[14:0], v[15]};
            `OP_WORD_ROR: shift_one = {16'h0000, v[0], v[15:1]};
            `OP_PAIR_LSL: shift_one = {v[30:0], 1'b0};
            `OP_PAIR_LSR: shift_one = {1'b0, v[31:1]};
            `OP_PAIR_ASL: shift_one = {v[30:0], 1'b0};
            `OP_PAIR_ASR: shift_one = {sign, v[31:1]};
            `OP_PAIR_ROL: shift_one = {v[30:0], v[31]};
            `OP_PAIR_ROR: shift_one = {v[0], v[31:1]};
            default: shift_one = v;
        endcase
    endfunction : shift_one

    assign pair_res = shift_one(core_reg.ins.opcode, {core_reg.hi, core_reg.lo},
                                is_pair(core_reg.ins.opcode));

    // next-state logic for the whole engine
    always_comb begin
        core_next = core_reg;
        core_next.rd_en = 1'b0;
        core_next.wr_en = 1'b0;
        core_next.logic_load = 1'b0;
        core_next.timer_refresh = 1'b0;
        unique case (core_reg.state)
            plc_shift_pkg::st_fetch: begin
                core_next.ins = i_instr;
                core_next.rd_area = i_instr.area;
                core_next.rd_addr = i_instr.addr;
                core_next.pc = core_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
                core_next.state = plc_shift_pkg::st_fetch;
                if (is_shift(i_instr.opcode) || i_instr.opcode == `OP_JUMP) begin
                    core_next.rd_en = 1'b1;
                    core_next.rd_area = (i_instr.opcode == `OP_JUMP) ? 1'b0 : i_instr.area;
                    core_next.state = plc_shift_pkg::st_read_lo;
                end else if (i_instr.opcode == `OP_STACK_PUSH) begin
                    // full stack refuses the push and flags it
                    if (core_reg.depth < 4'(STACK_DEPTH)) begin
                        core_next.stack = {core_reg.stack[STACK_DEPTH-2:0], i_logic_result};
                        core_next.depth = core_reg.depth + 4'h1;
                    end else begin
                        core_next.overflow = 1'b1;
                    end
                end else if (i_instr.opcode == `OP_STACK_PEEK) begin
                    core_next.logic_load = (core_reg.depth != 4'h0);
                    core_next.logic_value = core_reg.stack[0];
                end else if (i_instr.opcode == `OP_STACK_POP) begin
                    if (core_reg.depth != 4'h0) begin
                        core_next.logic_load = 1'b1;
                        core_next.logic_value = core_reg.stack[0];
                        core_next.stack = {1'b0, core_reg.stack[STACK_DEPTH-1:1]};
                        core_next.depth = core_reg.depth - 4'h1;
                    end
                end else if (i_instr.opcode == `OP_END) begin
                    core_next.timer_refresh = 1'b1;
                    core_next.pc = `PC_ZERO;
                    core_next.state = plc_shift_pkg::st_wait_loop;
                end else if (core_reg.pc >= i_prog_last) begin
                    // ran past the end without jump or end
                    core_next.state = plc_shift_pkg::st_halted;
                end
            end
            plc_shift_pkg::st_read_lo: begin
                // read data arrives this cycle for the request issued at fetch
                core_next.lo = i_rd_data;
                core_next.hi = 16'h0000;
                if (core_reg.ins.opcode == `OP_JUMP) begin
                    core_next.pc = i_rd_data[PC_WIDTH-1:0];
                    core_next.timer_refresh = 1'b1;
                    core_next.state = plc_shift_pkg::st_wait_loop;
                end else if (is_pair(core_reg.ins.opcode)) begin
                    core_next.rd_en = 1'b1;
                    core_next.rd_addr = core_reg.ins.addr + 8'h01;
                    core_next.state = plc_shift_pkg::st_read_hi;
                end else begin
                    core_next.state = plc_shift_pkg::st_write_lo;
                end
            end
            plc_shift_pkg::st_read_hi: begin
                core_next.hi = i_rd_data;
                core_next.state = plc_shift_pkg::st_write_lo;
            end
            plc_shift_pkg::st_write_lo: begin
                // low half always returns to the named register
                core_next.wr_en = 1'b1;
                core_next.wr_area = core_reg.ins.area;
                core_next.wr_addr = core_reg.ins.addr;
                core_next.wr_data = pair_res[15:0];
                core_next.hi = pair_res[31:16];
                core_next.state = is_pair(core_reg.ins.opcode) ? plc_shift_pkg::st_write_hi
                                                               : plc_shift_pkg::st_fetch;
            end
            plc_shift_pkg::st_write_hi: begin
                core_next.wr_en = 1'b1;
                core_next.wr_addr = core_reg.ins.addr + 8'h01;
                core_next.wr_data = core_reg.hi;
                core_next.state = plc_shift_pkg::st_fetch;
            end
            plc_shift_pkg::st_wait_loop: begin
                // rest of the pass is skipped, not executed
                if (i_loop_start) begin
                    core_next.state = plc_shift_pkg::st_fetch;
                end
            end
            plc_shift_pkg::st_halted: begin
                core_next.state = plc_shift_pkg::st_halted;
            end
        endcase
        // status flags registered so the outputs come from flops
        core_next.running = (core_next.state != plc_shift_pkg::st_wait_loop)
            && (core_next.state != plc_shift_pkg::st_halted);
        core_next.halted = (core_next.state == plc_shift_pkg::st_halted);
    end

    // single state register; reset clears all but the state, which loads st_wait_loop
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            core_reg <= '0;
            core_reg.state <= plc_shift_pkg::st_wait_loop;
        end else begin
            core_reg <= core_next;
        end
    end

    assign o_pc = core_reg.pc;
    assign o_rd_en = core_reg.rd_en;
    assign o_rd_area = core_reg.rd_area;
    assign o_rd_addr = core_reg.rd_addr;
    assign o_wr_en = core_reg.wr_en;
    assign o_wr_area = core_reg.wr_area;
    assign o_wr_addr = core_reg.wr_addr;
    assign o_wr_data = core_reg.wr_data;
    assign o_logic_load = core_reg.logic_load;
    assign o_logic_value = core_reg.logic_value;
    assign o_timer_refresh = core_reg.timer_refresh;
    assign o_stack_overflow = core_reg.overflow;
    assign o_running = core_reg.running;
    assign o_halted = core_reg.halted;
endmodule : plc_shift_and_flow_control

// ### test/plc_shift_and_flow_control_properties.sv
// Purpose: port timing checks for the shift and flow-control engine
// Assumes: one clock, synchronous active-high reset
// Notes: write strobes are told apart by how far back the reads were
module plc_shift_and_flow_control_properties #(
    parameter int PC_WIDTH = 16
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [PC_WIDTH-1:0] o_pc,
    input wire logic o_rd_en,
    input wire logic o_wr_en,
    input wire logic o_wr_area,
    input wire logic [7:0] o_wr_addr,
    input wire logic o_timer_refresh,
    input wire logic o_stack_overflow,
    input wire logic o_running,
    input wire logic o_halted
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // every write follows its read by two or three cycles
    a_write_after_read: assert property (o_wr_en |-> $past(o_rd_en, 2) || $past(o_rd_en, 3))
        else $error("write without a read before it");
    a_word_one_write: assert property (o_wr_en && !$past(o_wr_en) && !$past(o_rd_en, 3)
        |=> !o_wr_en)
        else $error("word write repeated");
    a_pair_two_writes: assert property (o_wr_en && !$past(o_wr_en) && $past(o_rd_en, 3)
        |=> o_wr_en)
        else $error("pair high half missing");
    a_pair_high_addr: assert property (o_wr_en && $past(o_wr_en) |->
        o_wr_addr == $past(o_wr_addr) + 8'h01 && o_wr_area == $past(o_wr_area))
        else $error("pair high half at wrong place");
    a_overflow_sticky: assert property (o_stack_overflow |=> o_stack_overflow)
        else $error("overflow flag dropped");
    a_halt_stays: assert property (o_halted |=> o_halted && !o_running)
        else $error("halt left without reset");
    a_refresh_idle: assert property (o_timer_refresh |-> ##2 !o_running)
        else $error("no idle after jump or end");
    a_end_to_zero: assert property (o_timer_refresh && !$past(o_rd_en) && !$past(o_rd_en, 2)
        |-> o_pc == '0)
        else $error("end did not return to zero");
    a_idle_quiet: assert property (!o_running |-> !o_wr_en)
        else $error("write while idle");
endmodule : plc_shift_and_flow_control_properties

bind plc_shift_and_flow_control plc_shift_and_flow_control_properties #(.PC_WIDTH(PC_WIDTH))
    i_props (.i_clock, .i_rst, .o_pc, .o_rd_en, .o_wr_en, .o_wr_area, .o_wr_addr,
    .o_timer_refresh, .o_stack_overflow, .o_running, .o_halted);

// ### test/tb_plc_shift_and_flow_control.sv
// Purpose: self-checking bench, program run against a queue model
// Assumes: read data answered in the cycle of the request
// Notes: register file and program held in the bench
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_plc_shift_and_flow_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 0, i_rst = 1, i_loop_start = 0, i_logic_result = 0;
    logic [15:0] i_prog_last = 16'd45, i_rd_data = 16'h0000, o_pc, o_wr_data;
    plc_shift_pkg::instr_t i_instr = '0, prog [64];
    logic o_rd_en, o_rd_area, o_wr_en, o_wr_area, o_logic_load, o_logic_value;
    logic o_timer_refresh, o_stack_overflow, o_running, o_halted;
    logic [7:0] o_rd_addr, o_wr_addr;
    logic [15:0] ram [512], mdl [512];
    logic lrb [64];
    logic [24:0] wq[$];
    logic lq[$], stk[$];
    int checks = 0, mismatches = 0, refreshes = 0;
    plc_shift_and_flow_control i_plc_shift_and_flow_control (.i_clock, .i_rst, .i_loop_start,
        .i_prog_last, .i_instr, .i_rd_data, .i_logic_result, .o_pc, .o_rd_en, .o_rd_area,
        .o_rd_addr, .o_wr_en, .o_wr_area, .o_wr_addr, .o_wr_data, .o_logic_load,
        .o_logic_value, .o_timer_refresh, .o_stack_overflow, .o_running, .o_halted);
    always #50 i_clock = ~i_clock;
    // one-bit shift model on a word (low half) or a pair
    function automatic logic [31:0] calc(logic [4:0] op, logic [31:0] v);
        logic [15:0] w;
        w = v[15:0];
        case (op)
            5'h00, 5'h04: calc = {16'h0000, w << 1};
            5'h01: calc = {16'h0000, w >> 1};
            5'h05: calc = {16'h0000, w[15], w[15:1]};
            5'h08: calc = {16'h0000, w[14:0], w[15]};
            5'h09: calc = {16'h0000, w[0], w[15:1]};
            5'h02, 5'h06: calc = v << 1;
            5'h03: calc = v >> 1;
            5'h07: calc = {v[31], v[31:1]};
            5'h0A: calc = {v[30:0], v[31]};
            default: calc = {v[0], v[31:1]};
        endcase
    endfunction : calc
    // far side: program, delayed read data (noise when idle), write capture
    always @(negedge i_clock) begin
        i_instr <= prog[o_pc[5:0]];
        i_logic_result <= lrb[o_pc[5:0]];
        // engine takes read data while its strobe stands
        i_rd_data <= (o_rd_en === 1'b1) ? ram[{o_rd_area, o_rd_addr}] : 16'($urandom);
        if (o_wr_en === 1'b1) begin
            `CHK({o_wr_area, o_wr_addr, o_wr_data}, wq.pop_front())
            ram[{o_wr_area, o_wr_addr}] <= o_wr_data;
        end
        if (o_logic_load === 1'b1) `CHK(o_logic_value, lq.pop_front())
        if (o_timer_refresh === 1'b1) refreshes++;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    // start a main-loop pass and wait, bounded, until the engine idles
    task automatic run_pass();
        int n;
        i_loop_start <= 1'b1;
        @(negedge i_clock);
        i_loop_start <= 1'b0;
        n = 0;
        while (o_running === 1'b1 && n < 500) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 500) mismatches++;
        repeat (10) @(negedge i_clock);
    endtask : run_pass
    initial begin
        #300000;
        mismatches++;
        complete_run();
    end
    initial begin
        logic [8:0] a;
        logic [31:0] r;
        logic [4:0] op;
        void'($urandom(35570));
        for (int k = 0; k < 512; k++) ram[k] = 16'($urandom);
        ram[255] = 16'd45;
        mdl = ram;
        for (int k = 0; k < 64; k++) begin
            prog[k] = '{5'h15, 1'b0, 8'h00};
            lrb[k] = 1'b0;
        end
        // all twelve shifts, working area then parameter area
        for (int k = 0; k < 24; k++) begin
            op = 5'(k % 12);
            a = {k >= 12, 8'($urandom_range(253))};
            prog[k] = '{op, a[8], a[7:0]};
            r = calc(op, {mdl[a + 9'h001], mdl[a]});
            mdl[a] = r[15:0];
            wq.push_back({a, r[15:0]});
            if (op[1]) begin
                mdl[a + 9'h001] = r[31:16];
                wq.push_back({a + 9'h001, r[31:16]});
            end
        end
        // nine pushes (last refused), one peek, nine pops (last on empty)
        for (int k = 24; k < 43; k++) begin
            op = k < 33 ? 5'h10 : (k == 33 ? 5'h11 : 5'h12);
            prog[k] = '{op, 1'b0, 8'h00};
            lrb[k] = 1'($urandom);
            if (op == 5'h10 && stk.size() < 8) stk.push_back(lrb[k]);
            else if (op != 5'h10 && stk.size() > 0) begin
                lq.push_back(stk[$]);
                if (op == 5'h12) void'(stk.pop_back());
            end
        end
        prog[43] = '{5'h13, 1'b0, 8'hFF};
        prog[45] = '{5'h14, 1'b0, 8'h00};
        repeat (20) @(negedge i_clock);
        i_rst <= 1'b0;
        @(negedge i_clock);
        run_pass();
        `CHK(wq.size() + lq.size(), 0)
        `CHK(o_stack_overflow, 1'b1)
        `CHK(o_pc, 16'd45)
        `CHK(o_running, 1'b0)
        `CHK(refreshes, 1)
        $display("test shifts, stack and jump done");
        run_pass();
        `CHK(o_pc, 16'h0000)
        `CHK(refreshes, 2)
        $display("test end done");
        i_prog_last <= 16'h0000;
        prog[0] = '{5'h15, 1'b0, 8'h00};
        @(negedge i_clock);
        run_pass();
        `CHK(o_halted, 1'b1)
        $display("test halt done");
        complete_run();
    end
endmodule : tb_plc_shift_and_flow_control
